/* File: design/fam_pkg.sv */
// fam_pkg: constants, register map and types of the flash array controller.
// assumes: one 250 MHz clock, APB register slave, 24-bit flash address space.
package fam_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned APB_AW   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned DWORD_W  = 64;
  localparam int unsigned PAGE_W   = 128;
  localparam int unsigned SECT_W   = 4;
  localparam int unsigned DW_LSB   = 3;
  localparam int unsigned PAGE_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // code array map
  localparam logic [ADDR_W-1:0] LOW_END_0      = 24'h008000;
  localparam logic [ADDR_W-1:0] LOW_END_1      = 24'h00C000;
  localparam logic [ADDR_W-1:0] LOW_END_2      = 24'h010000;
  localparam logic [ADDR_W-1:0] LOW_END_3      = 24'h018000;
  localparam logic [ADDR_W-1:0] LOW_END_4      = 24'h020000;
  localparam logic [ADDR_W-1:0] CODE_MID_BASE  = 24'h040000;
  localparam logic [ADDR_W-1:0] CODE_HIGH_BASE = 24'h080000;
  localparam logic [ADDR_W-1:0] CODE_HIGH_END  = 24'h100000;
  localparam logic [ADDR_W-1:0] SHADOW_BASE    = 24'h200000;
  localparam logic [ADDR_W-1:0] SHADOW_END     = 24'h204000;
  localparam logic [ADDR_W-1:0] TEST_BASE      = 24'h400000;
  localparam logic [ADDR_W-1:0] TEST_END       = 24'h800000;
  // data array map
  localparam logic [ADDR_W-1:0] DATA_BASE      = 24'h800000;
  localparam logic [ADDR_W-1:0] DATA_END       = 24'h810000;
  localparam logic [ADDR_W-1:0] DTEST_BASE     = 24'hC00000;
  localparam logic [ADDR_W-1:0] DTEST_END      = 24'hC04000;
  localparam logic [SECT_W-1:0] MID_SECT_BASE  = 4'h6;
  localparam logic [SECT_W-1:0] HIGH_SECT_BASE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  localparam logic [APB_AW-1:0] OFS_CFG   = 12'h000;
  localparam logic [APB_AW-1:0] OFS_LOCK  = 12'h004;
  localparam logic [APB_AW-1:0] OFS_EADDR = 12'h008;
  localparam logic [APB_AW-1:0] OFS_STS   = 12'h00C;
  localparam logic [APB_AW-1:0] OFS_MASK  = 12'h010;

  localparam logic [DATA_W-1:0] CFG_RESET     = 32'h03200600;
  localparam int unsigned       CFG_PGM_BIT   = 4;
  localparam logic [DATA_W-1:0] EADDR_RESET   = 32'h0000C000;
  localparam logic [DATA_W-1:0] LOCK_PASSWORD = 32'hB2B22222;
  localparam logic [DATA_W-1:0] LOCK_UNLOCKED = 32'h80000FF2;
  localparam logic [DATA_W-1:0] LOCK_ABSENT   = 32'h00000FF0;
  localparam int unsigned       LOCK_EN_BIT   = 31;
  localparam int unsigned       HIGH_SECTORS  = 4;
  localparam logic [HIGH_SECTORS-1:0] LOCK_BITS_RESET = 4'hF;

  localparam int unsigned IRQ_W      = 3;
  localparam int unsigned IRQ_ECC    = 0;
  localparam int unsigned IRQ_BUSERR = 1;
  localparam int unsigned IRQ_REFUSE = 2;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    RG_CODE   = 3'h0,
    RG_SHADOW = 3'h1,
    RG_TEST   = 3'h2,
    RG_DATA   = 3'h3,
    RG_DTEST  = 3'h4,
    RG_RSVD   = 3'h5
  } fam_region_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b11,
    ST_RESP  = 2'b10
  } fam_state_t;

endpackage

/* File: design/fam_decode.sv */
// fam_decode: combinational flash address decoder, region and sector number.
// assumes: address already registered by the caller.
`timescale 1ns/1ps
`default_nettype none
module fam_decode (
  input  wire logic [fam_pkg::ADDR_W-1:0] addr,
  output fam_pkg::fam_region_t            region,
  output logic [fam_pkg::SECT_W-1:0]      sector,
  output logic                            hit
);
  import fam_pkg::*;

  function automatic logic [SECT_W-1:0] low_sector(input logic [ADDR_W-1:0] a);
    if (a < LOW_END_0) begin
      return 4'h0;
    end else if (a < LOW_END_1) begin
      return 4'h1;
    end else if (a < LOW_END_2) begin
      return 4'h2;
    end else if (a < LOW_END_3) begin
      return 4'h3;
    end else if (a < LOW_END_4) begin
      return 4'h4;
    end
    return 4'h5;
  endfunction

  always_comb begin
    region = RG_RSVD;
    sector = '0;
    hit    = 1'b0;
    if (addr < CODE_MID_BASE) begin // R3
      region = RG_CODE;
      sector = low_sector(addr);
      hit    = 1'b1;
    end else if (addr < CODE_HIGH_BASE) begin // R3
      region = RG_CODE;
      sector = MID_SECT_BASE | SECT_W'(addr[17]);
      hit    = 1'b1;
    end else if (addr < CODE_HIGH_END) begin // R3
      region = RG_CODE;
      sector = HIGH_SECT_BASE | SECT_W'(addr[18:17]);
      hit    = 1'b1;
    end else if (addr >= SHADOW_BASE && addr < SHADOW_END) begin // R4
      region = RG_SHADOW;
      hit    = 1'b1;
    end else if (addr >= TEST_BASE && addr < TEST_END) begin // R4
      region = RG_TEST;
      hit    = 1'b1;
    end else if (addr >= DATA_BASE && addr < DATA_END) begin // R9
      region = RG_DATA;
      sector = SECT_W'(addr[15:14]);
      hit    = 1'b1;
    end else if (addr >= DTEST_BASE && addr < DTEST_END) begin // R9
      region = RG_DTEST;
      hit    = 1'b1;
    end
  end

endmodule // fam_decode
`default_nettype wire

/* File: design/fam_ctrl.sv */
// fam_ctrl: flash array controller, one array port, APB config registers.
// assumes: array answers a one-cycle strobe with ARR_DONE, inputs synchronous.
//
// Function
// R1: all masters reach the 1 MB code array through one single array port.
// R2: programming goes one doubleword at a time and a read fetches a whole page.
// R3: code space is six low sectors below 0x40000, two 128K mid and 128K high sectors.
// R4: a 16K shadow sector at 0x200000, test from 0x400000, reserved in the gaps.
// R5: the module configuration register reads 0x03200600 after reset.
// R6: error address resets to 0x0000C000 and captures the address of an ECC error.
// R7: writing the password twice to the high-space lock makes it read 0x80000FF2.
// R8: only four high sectors have lock bits and the absent ones read as set.
// R9: data array is four 16K sectors from 0x800000 and a 16K test region at 0xC00000.
// R10: an access to reserved or unpopulated flash space gets an error answer.
`timescale 1ns/1ps
`default_nettype none
module fam_ctrl (
  input  wire logic                         SYS_CLK,
  input  wire logic                         RESET,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [fam_pkg::APB_AW-1:0]   PADDR,
  input  wire logic [fam_pkg::DATA_W-1:0]   PWDATA,
  output logic      [fam_pkg::DATA_W-1:0]   PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  input  wire logic                         FA_REQ,
  input  wire logic                         FA_WR,
  input  wire logic [fam_pkg::ADDR_W-1:0]   FA_ADDR,
  input  wire logic [fam_pkg::DWORD_W-1:0]  FA_WDATA,
  output logic                              FA_ACK,
  output logic                              FA_ERR,
  output logic      [fam_pkg::PAGE_W-1:0]   FA_RDATA,
  output logic                              ARR_RD,
  output logic                              ARR_WR,
  output logic      [fam_pkg::ADDR_W-1:0]   ARR_ADDR,
  output logic      [fam_pkg::DWORD_W-1:0]  ARR_WDATA,
  input  wire logic                         ARR_DONE,
  input  wire logic                         ARR_ECC_ERR,
  input  wire logic [fam_pkg::PAGE_W-1:0]   ARR_PAGE,
  output logic                              IRQ
);
  import fam_pkg::*;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                    apb_setup;
  logic                    apb_done;
  logic                    wr_cfg;
  logic                    wr_lock;
  logic                    wr_sts;
  logic                    wr_mask;
  logic [DATA_W-1:0]       rd_mux;
  logic [DATA_W-1:0]       cfg_rd;
  logic [DATA_W-1:0]       lock_rd;
  logic                    cfg_pgm_q;
  logic                    pw_seen_q;
  logic                    lock_en_q;
  logic [HIGH_SECTORS-1:0] lock_bits_q;
  logic [DATA_W-1:0]       err_addr_q;
  logic [IRQ_W-1:0]        sts_q;
  logic [IRQ_W-1:0]        sts_d;
  logic [IRQ_W-1:0]        mask_q;
  logic [IRQ_W-1:0]        ev;
  fam_state_t              state_q;
  logic [ADDR_W-1:0]       req_addr_q;
  logic                    req_wr_q;
  logic [DWORD_W-1:0]      req_wdata_q;
  fam_region_t             dec_region;
  logic [SECT_W-1:0]       dec_sector;
  logic                    dec_hit;
  logic                    high_sect;
  logic                    wr_refused;
  logic                    issue_err;

  function automatic logic reg_hit(input logic [APB_AW-1:0] a);
    return a == OFS_CFG || a == OFS_LOCK || a == OFS_EADDR ||
           a == OFS_STS || a == OFS_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: answers in the first access cycle, no wait states
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_done  = PSEL & PENABLE & PREADY;
  assign wr_cfg    = apb_done & PWRITE & (PADDR == OFS_CFG);
  assign wr_lock   = apb_done & PWRITE & (PADDR == OFS_LOCK);
  assign wr_sts    = apb_done & PWRITE & (PADDR == OFS_STS);
  assign wr_mask   = apb_done & PWRITE & (PADDR == OFS_MASK);

  // size nibble stays that of the 1 MB array; only the program enable is live
  assign cfg_rd  = CFG_RESET | (DATA_W'(cfg_pgm_q) << CFG_PGM_BIT); // R5
  assign lock_rd = (DATA_W'(lock_en_q) << LOCK_EN_BIT) | LOCK_ABSENT |
                   DATA_W'(lock_bits_q); // R8

  always_comb begin
    rd_mux = '0;
    unique case (PADDR)
      OFS_CFG:   rd_mux = cfg_rd;
      OFS_LOCK:  rd_mux = lock_rd;
      OFS_EADDR: rd_mux = err_addr_q;
      OFS_STS:   rd_mux = DATA_W'(sts_q);
      OFS_MASK:  rd_mux = DATA_W'(mask_q);
      default:   rd_mux = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= apb_setup;
      PSLVERR <= apb_setup & ~reg_hit(PADDR);
      PRDATA  <= (apb_setup & ~PWRITE) ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and high-space lock
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      cfg_pgm_q <= 1'b0;
    end else if (wr_cfg) begin
      cfg_pgm_q <= PWDATA[CFG_PGM_BIT];
    end
  end

  // a wrong value in the password phase restarts the sequence
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      pw_seen_q   <= 1'b0;
      lock_en_q   <= 1'b0;
      lock_bits_q <= LOCK_BITS_RESET;
    end else if (wr_lock) begin
      if (lock_en_q) begin
        lock_bits_q <= PWDATA[HIGH_SECTORS-1:0]; // R8
      end else if (PWDATA == LOCK_PASSWORD) begin
        if (pw_seen_q) begin
          lock_en_q   <= 1'b1; // R7
          lock_bits_q <= PWDATA[HIGH_SECTORS-1:0]; // R7
        end
        pw_seen_q <= 1'b1;
      end else begin
        pw_seen_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request checks
  fam_decode u_decode (
    .addr   (req_addr_q),
    .region (dec_region),
    .sector (dec_sector),
    .hit    (dec_hit)
  );

  assign high_sect  = (dec_region == RG_CODE) && (dec_sector >= HIGH_SECT_BASE);
  // writes need program enable, doubleword alignment and, in a high sector, a clear lock bit
  assign wr_refused = req_wr_q & (~cfg_pgm_q | (|req_addr_q[DW_LSB-1:0]) |
                      (high_sect & lock_bits_q[dec_sector[1:0]])); // R2 R8
  assign issue_err  = ~dec_hit | wr_refused; // R10

  ////////////////////////////////////////////////////////////////////////////
  // array port sequencer: the only path into the array
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_q     <= ST_IDLE;
      req_addr_q  <= '0;
      req_wr_q    <= 1'b0;
      req_wdata_q <= '0;
      FA_ACK      <= 1'b0;
      FA_ERR      <= 1'b0;
      FA_RDATA    <= '0;
      ARR_RD      <= 1'b0;
      ARR_WR      <= 1'b0;
      ARR_ADDR    <= '0;
      ARR_WDATA   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (FA_REQ) begin // R1
            req_addr_q  <= FA_ADDR;
            req_wr_q    <= FA_WR;
            req_wdata_q <= FA_WDATA;
            state_q     <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (issue_err) begin
            FA_ACK  <= 1'b1; // R10
            FA_ERR  <= 1'b1; // R10
            state_q <= ST_RESP;
          end else if (req_wr_q) begin
            ARR_WR    <= 1'b1; // R2
            ARR_ADDR  <= req_addr_q;
            ARR_WDATA <= req_wdata_q;
            state_q   <= ST_WAIT;
          end else begin
            ARR_RD   <= 1'b1; // R2
            ARR_ADDR <= {req_addr_q[ADDR_W-1:PAGE_LSB], PAGE_LSB'(0)}; // R2
            state_q  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          ARR_RD <= 1'b0;
          ARR_WR <= 1'b0;
          if (ARR_DONE) begin
            FA_ACK   <= 1'b1;
            FA_ERR   <= ARR_ECC_ERR;
            FA_RDATA <= req_wr_q ? '0 : ARR_PAGE;
            state_q  <= ST_RESP;
          end
        end
        ST_RESP: begin
          FA_ACK  <= 1'b0;
          FA_ERR  <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error address capture
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      err_addr_q <= EADDR_RESET; // R6
    end else if (ev[IRQ_ECC]) begin
      err_addr_q <= DATA_W'(req_addr_q); // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, a new event beats the clear
  assign ev[IRQ_ECC]    = (state_q == ST_WAIT) & ARR_DONE & ARR_ECC_ERR;
  assign ev[IRQ_BUSERR] = (state_q == ST_ISSUE) & ~dec_hit;
  assign ev[IRQ_REFUSE] = (state_q == ST_ISSUE) & dec_hit & wr_refused;
  assign sts_d = (sts_q & ~(wr_sts ? PWDATA[IRQ_W-1:0] : '0)) | ev;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sts_q  <= '0;
      mask_q <= '0;
      IRQ    <= 1'b0;
    end else begin
      sts_q <= sts_d;
      if (wr_mask) begin
        mask_q <= PWDATA[IRQ_W-1:0];
      end
      IRQ <= |(sts_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_one_port;
    (ARR_RD || ARR_WR) |-> (state_q == ST_WAIT) && !(ARR_RD && ARR_WR) ##1 !ARR_RD && !ARR_WR;
  endproperty
  a_one_port: assert property (p_one_port) else $error("array strobe not single"); // R1

  property p_granule;
    (ARR_RD |-> ARR_ADDR[PAGE_LSB-1:0] == '0) and (ARR_WR |-> ARR_ADDR[DW_LSB-1:0] == '0);
  endproperty
  a_granule: assert property (p_granule) else $error("array access misaligned"); // R2

  // sector index worked out from the sector size, not from address bits
  property p_code_map;
    (state_q == ST_ISSUE && req_addr_q >= CODE_HIGH_BASE && req_addr_q < CODE_HIGH_END)
      |-> dec_hit && dec_sector == (HIGH_SECT_BASE + SECT_W'(32'(req_addr_q - CODE_HIGH_BASE) /
          (32'(CODE_HIGH_END - CODE_HIGH_BASE) / HIGH_SECTORS)));
  endproperty
  a_code_map: assert property (p_code_map) else $error("high sector decode wrong"); // R3

  property p_low_map;
    (state_q == ST_ISSUE && req_addr_q >= LOW_END_4 && req_addr_q < CODE_MID_BASE)
      |-> dec_region == RG_CODE && dec_sector == 4'h5;
  endproperty
  a_low_map: assert property (p_low_map) else $error("last low sector decode wrong"); // R3

  property p_shadow_map;
    (state_q == ST_ISSUE && req_addr_q >= SHADOW_BASE && req_addr_q < SHADOW_END)
      |-> dec_region == RG_SHADOW ##1 !FA_ERR || req_wr_q;
  endproperty
  a_shadow_map: assert property (p_shadow_map) else $error("shadow sector decode wrong"); // R4

  property p_cfg_reset;
    $fell(RESET) |-> cfg_rd == CFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong"); // R5

  property p_err_capture;
    ev[IRQ_ECC] |=> err_addr_q == DATA_W'($past(req_addr_q)) && sts_q[IRQ_ECC];
  endproperty
  a_err_capture: assert property (p_err_capture) else $error("ecc address not captured"); // R6

  property p_password;
    (wr_lock && !lock_en_q && pw_seen_q && PWDATA == LOCK_PASSWORD)
      |=> lock_rd == LOCK_UNLOCKED;
  endproperty
  a_password: assert property (p_password) else $error("lock register not unlocked"); // R7

  property p_locked_write;
    (state_q == ST_ISSUE && req_wr_q && high_sect && lock_bits_q[dec_sector[1:0]])
      |=> FA_ACK && FA_ERR && !ARR_WR ##1 !FA_ACK;
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked sector written"); // R8

  // data sectors share the 16K size of the data test region
  property p_data_map;
    (state_q == ST_ISSUE && req_addr_q >= DATA_BASE && req_addr_q < DATA_END)
      |-> dec_region == RG_DATA &&
          dec_sector == SECT_W'(32'(req_addr_q - DATA_BASE) / 32'(DTEST_END - DTEST_BASE));
  endproperty
  a_data_map: assert property (p_data_map) else $error("data sector decode wrong"); // R9

  property p_dword_align;
    (state_q == ST_ISSUE && req_wr_q && req_addr_q[DW_LSB-1:0] != '0) |=> FA_ERR && !ARR_WR;
  endproperty
  a_dword_align: assert property (p_dword_align) else $error("misaligned write not refused"); // R2

  property p_ack_pulse;
    FA_ACK |=> !FA_ACK && !ARR_RD && !ARR_WR;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle"); // R1

  // a clear in the event cycle must not swallow the event
  property p_event_sticks;
    ev != '0 |=> (sts_q & $past(ev)) == $past(ev);
  endproperty
  a_event_sticks: assert property (p_event_sticks) else $error("status event lost"); // R6

  property p_irq_level;
    (sts_q & mask_q) != '0 |=> IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised"); // R6

  property p_reserved;
    (state_q == ST_ISSUE && !dec_hit) |=> FA_ACK && FA_ERR && !ARR_RD && !ARR_WR;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved access not refused"); // R10

endmodule // fam_ctrl
`default_nettype wire

/* File: bench/fam_array_model.sv */
// fam_array_model: behavioural flash array behind the single strobe port.
// assumes: one strobe outstanding at a time; bench sets latency and ecc injection.
`timescale 1ns/1ps
`default_nettype none
module fam_array_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  lat,
  input  wire logic        ecc_on,
  input  wire logic        arr_rd,
  input  wire logic        arr_wr,
  input  wire logic [23:0] arr_addr,
  input  wire logic [63:0] arr_wdata,
  output logic             arr_done,
  output logic             arr_ecc_err,
  output logic [127:0]     arr_page,
  output logic [23:0]      wr_addr,
  output logic [63:0]      wr_data,
  output int               n_acc
);
  logic         pend_q;
  logic [3:0]   cnt_q;
  logic [23:0]  addr_q;
  logic [127:0] last_q;
  logic [23:0]  a_sel;
  logic [31:0]  base;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      cnt_q  <= 4'h0;
      addr_q <= 24'h000000;
    end else if ((arr_rd || arr_wr) && lat != 4'h0) begin
      pend_q <= 1'b1;
      cnt_q  <= 4'h1;
      addr_q <= arr_addr;
    end else if (pend_q) begin
      pend_q <= (cnt_q != lat);
      cnt_q  <= cnt_q + 4'h1;
    end
  end
  // every strobe counted, so refused requests that leak show up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_acc   <= 0;
      wr_addr <= 24'h000000;
      wr_data <= 64'h0;
    end else if (arr_rd || arr_wr) begin
      n_acc <= n_acc + 1;
      if (arr_wr) begin
        wr_addr <= arr_addr;
        wr_data <= arr_wdata;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (arr_done) begin
      last_q <= arr_page;
    end
  end
  // zero latency answers in the strobe cycle itself
  assign a_sel    = (lat == 4'h0) ? arr_addr : addr_q;
  assign arr_done = (lat == 4'h0) ? (arr_rd || arr_wr) : (pend_q && cnt_q == lat);
  assign base     = {8'h00, a_sel[23:4], 4'h0};
  // outside an answer the page bus shows the inverse, never stale data
  assign arr_page    = arr_done ? {base, ~base, base ^ 32'h5A5A5A5A, base + 32'h1} : ~last_q;
  assign arr_ecc_err = arr_done ? ecc_on : ~ecc_on;
endmodule // fam_array_model
`default_nettype wire

/* File: bench/fam_ctrl_tb.sv */
// fam_ctrl_tb: APB and flash port sequences against fam_ctrl and the array model.
// assumes: fam_pkg compiled first; 250 MHz clock; zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
module fam_ctrl_tb import fam_pkg::*; ;
  logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, fa_ack, fa_err, arr_rd, arr_wr, arr_done, arr_ecc_err, irq;
  logic fa_req = 1'b0, fa_wr = 1'b0, ecc_on = 1'b0, e;
  logic [23:0] fa_addr = 24'h0, arr_addr, wr_addr;
  logic [63:0] fa_wdata = 64'h0, arr_wdata, wr_data;
  logic [127:0] fa_rdata, arr_page, pg;
  logic [3:0] lat = 4'h0;
  logic [31:0] rd;
  int n_mismatch = 0, checks_done = 0, cycles = 0, n_acc, n_ok = 0;
  localparam logic [23:0] RA [19] = '{24'h000004, 24'h03FFF4, 24'h040004, 24'h0FFFF4,
    24'h100004, 24'h1FFFF4, 24'h200004, 24'h203FF4, 24'h204004, 24'h3FFFF4, 24'h400004,
    24'h7FFFF4, 24'h800004, 24'h80FFF4, 24'h810004, 24'hBFFFF4, 24'hC00004, 24'hC03FF4,
    24'hC04004};
  localparam logic [18:0] RERR = 19'h4C330;
  localparam logic [63:0] DW   = 64'h0123456789ABCDEF;

  fam_ctrl i_dut (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FA_REQ(fa_req), .FA_WR(fa_wr), .FA_ADDR(fa_addr),
    .FA_WDATA(fa_wdata), .FA_ACK(fa_ack), .FA_ERR(fa_err), .FA_RDATA(fa_rdata),
    .ARR_RD(arr_rd), .ARR_WR(arr_wr), .ARR_ADDR(arr_addr), .ARR_WDATA(arr_wdata),
    .ARR_DONE(arr_done), .ARR_ECC_ERR(arr_ecc_err), .ARR_PAGE(arr_page), .IRQ(irq));
  fam_array_model i_arr (.clk(sys_clk), .rst(reset), .lat(lat), .ecc_on(ecc_on),
    .arr_rd(arr_rd), .arr_wr(arr_wr), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_done(arr_done), .arr_ecc_err(arr_ecc_err), .arr_page(arr_page),
    .wr_addr(wr_addr), .wr_data(wr_data), .n_acc(n_acc));

  always #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ready and data are taken at the same edge, before the slave updates them
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
  endtask
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
    chk(e, xe);
  endtask
  task automatic fa(input logic w, input logic [23:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    fa_req <= 1'b1; fa_wr <= w; fa_addr <= a; fa_wdata <= d;
    do @(posedge sys_clk); while (fa_ack !== 1'b1);
    e = fa_err; pg = fa_rdata;
    fa_req <= 1'b0; fa_addr <= ~a; fa_wdata <= ~d;
    if (e !== 1'b1) n_ok++;
  endtask
  function automatic logic [127:0] exp_page(input logic [23:0] a);
    logic [31:0] b;
    b = {8'h00, a[23:4], 4'h0};
    return {b, ~b, b ^ 32'h5A5A5A5A, b + 32'h1};
  endfunction
  task automatic irq_is(input logic x);
    repeat (2) @(posedge sys_clk);
    chk(irq, x);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    reg_rd(OFS_CFG, CFG_RESET, 1'b0);
    reg_rd(OFS_EADDR, EADDR_RESET, 1'b0);
    reg_rd(OFS_LOCK, 32'h00000FFF, 1'b0);
    reg_rd(OFS_STS, 32'h0, 1'b0);
    reg_rd(12'h014, 32'h0, 1'b1);
    for (int i = 0; i < 19; i++) begin
      lat <= 4'(i % 3);
      fa(1'b0, RA[i], 64'h0);
      chk(e, RERR[i]);
      if (!RERR[i]) chk(pg, exp_page(RA[i]));
    end
    fa(1'b1, 24'h000008, DW);
    chk(e, 1'b1);
    apb(1'b1, OFS_CFG, 32'hFFFFFFFF);
    reg_rd(OFS_CFG, CFG_RESET | 32'h10, 1'b0);
    fa(1'b1, 24'h000008, DW);
    chk(e, 1'b0);
    chk(wr_addr, 24'h000008);
    chk(wr_data, DW);
    chk(pg, 128'h0);
    fa(1'b1, 24'h00000C, DW);
    chk(e, 1'b1);
    apb(1'b1, OFS_LOCK, LOCK_PASSWORD);
    apb(1'b1, OFS_LOCK, 32'h12345678);
    apb(1'b1, OFS_LOCK, LOCK_PASSWORD);
    reg_rd(OFS_LOCK, 32'h00000FFF, 1'b0);
    apb(1'b1, OFS_LOCK, LOCK_PASSWORD);
    reg_rd(OFS_LOCK, LOCK_UNLOCKED, 1'b0);
    fa(1'b1, 24'h0A0000, DW);
    chk(e, 1'b1);
    fa(1'b1, 24'h080000, DW);
    chk(e, 1'b0);
    apb(1'b1, OFS_LOCK, 32'hFFFFFFF0);
    reg_rd(OFS_LOCK, 32'h80000FF0, 1'b0);
    fa(1'b1, 24'h0A0000, DW);
    chk(e, 1'b0);
    chk(wr_addr, 24'h0A0000);
    ecc_on <= 1'b1;
    fa(1'b0, 24'h012340, 64'h0);
    chk(e, 1'b1);
    chk(pg, exp_page(24'h012340));
    n_ok++;
    ecc_on <= 1'b0;
    reg_rd(OFS_EADDR, 32'h00012340, 1'b0);
    chk(n_acc, n_ok);
    reg_rd(OFS_STS, 32'h7, 1'b0);
    irq_is(1'b0);
    apb(1'b1, OFS_MASK, 32'h1);
    irq_is(1'b1);
    apb(1'b1, OFS_STS, 32'h1);
    irq_is(1'b0);
    reg_rd(OFS_STS, 32'h6, 1'b0);
    apb(1'b1, OFS_MASK, 32'h6);
    irq_is(1'b1);
    apb(1'b1, OFS_STS, 32'h6);
    irq_is(1'b0);
    reg_rd(OFS_MASK, 32'h6, 1'b0);
    tally_and_finish();
  end
endmodule // fam_ctrl_tb
`default_nettype wire
